// file: src/mab_top.sv
// memory access routing and external bus sequencer
`timescale 1ns/1ps
// Summary of operation
// - ext_fetch_select_n low forces external code fetch; high keeps code fetch internal
// - program fetch strobe pulses only on external code reads
// - address latch strobe runs at one sixth of oscillator rate
// - latch strobe pulses while low address sits on low port
// - high port carries upper address during external access
// - reset must be held high two machine cycles with clock running
// - two 256 byte internal banks: scratchpad and auxiliary
// - lower scratchpad reachable directly and through index registers
// - upper scratchpad reachable only indirectly
// - enabled auxiliary RAM served by index register or data pointer
// - external-data moves above auxiliary range use the external bus
// - auxiliary RAM disabled after reset
// - chip control bit 4 enables auxiliary RAM
// - enabled: index-register external moves always hit auxiliary RAM
// - internal execution: auxiliary access leaves ports and strobes alone
// - oscillator divided by two before internal use
// - reset sampled at one fixed state of each machine cycle
// - reset sets port output latches to all ones
module mab_top (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        reset_pin_i,
  input  wire logic        ext_fetch_select_n_i,
  // core side
  input  wire logic        fetch_req_i,
  input  wire logic [15:0] pc_i,
  input  wire logic        sp_req_i,
  input  wire logic        sp_we_i,
  input  wire logic        sp_indirect_i,
  input  wire logic [7:0]  sp_addr_i,
  input  wire logic [7:0]  sp_wdata_i,
  input  wire logic        xmov_req_i,
  input  wire logic        xmov_we_i,
  input  wire logic        xmov_use_data_pointer16_i,
  input  wire logic [7:0]  index_reg_i,
  input  wire logic [15:0] data_pointer16_i,
  input  wire logic [7:0]  xmov_wdata_i,
  input  wire logic        chip_ctrl_we_i,
  input  wire logic [7:0]  chip_ctrl_wdata_i,
  input  wire logic [7:0]  port0_latch_i,
  input  wire logic [7:0]  port2_latch_i,
  input  wire logic        port_latch_we_i,
  // external bus
  input  wire logic [7:0]  low_addr_data_port_i,
  output logic      [7:0]  low_addr_data_port_o,
  output logic             low_addr_data_port_oe_o,
  output logic      [7:0]  high_addr_port_o,
  output logic             program_fetch_strobe_n_o,
  output logic             addr_latch_strobe_o,
  output logic             ext_rd_n_o,
  output logic             ext_wr_n_o,
  // core answers
  output logic      [7:0]  rdata_o,
  output logic             rvalid_o,
  output logic             busy_o,
  output logic      [7:0]  chip_control_reg_o,
  output logic             reset_active_o
);
  import mab_pkg::*;

  logic       phase_en;
  logic [2:0] st;
  mab_clkdiv u_div (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n_i),
    .phase_en_o (phase_en),
    .state_o    (st)
  );

  // synchronisers for pins
  logic rst_s1, rst_s2, ea_s1, ea_s2;
  logic [7:0] p0_s1, p0_s2;
  always_ff @(posedge clk_i) begin
    rst_s1 <= reset_pin_i;
    rst_s2 <= rst_s1;
    ea_s1  <= ext_fetch_select_n_i;
    ea_s2  <= ea_s1;
    p0_s1  <= low_addr_data_port_i;
    p0_s2  <= p0_s1;
  end

  // reset detect: count consecutive samples once per machine cycle
  wire sample_pt = phase_en && (st == SAMPLE_STATE);
  logic [1:0] rst_cnt;
  logic       dev_rst;
  wire hold_met = (rst_cnt == 2'(RST_HOLD_MC - 1));
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rst_cnt <= 2'h0;
      dev_rst <= 1'b1;
    end else if (sample_pt) begin
      if (!rst_s2) begin
        rst_cnt <= 2'h0;
        dev_rst <= 1'b0;
      end else if (hold_met) begin
        dev_rst <= 1'b1;
      end else begin
        rst_cnt <= rst_cnt + 2'h1;
      end
    end
  end

  // chip control register
  logic [7:0] chip_ctrl;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || dev_rst)
      chip_ctrl <= CHIP_CTRL_RST;
    else if (chip_ctrl_we_i)
      chip_ctrl <= chip_ctrl_wdata_i;
  end
  wire aux_en = chip_ctrl[AUX_EN_BIT];

  // port output latches
  logic [7:0] p0_latch, p2_latch;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || dev_rst) begin
      p0_latch <= PORT_RST;
      p2_latch <= PORT_RST;
    end else if (port_latch_we_i) begin
      p0_latch <= port0_latch_i;
      p2_latch <= port2_latch_i;
    end
  end

  // scratchpad routing: upper half only indirect
  wire sp_upper  = (sp_addr_i >= 8'(DIRECT_LIMIT));
  wire sp_ok     = sp_req_i && (sp_indirect_i || !sp_upper);
  wire sp_write  = sp_ok && sp_we_i;
  logic [7:0] sp_rdata, aux_rdata;
  mab_ram u_sp (
    .clk_i   (clk_i),
    .we_i    (sp_write),
    .addr_i  (sp_addr_i),
    .wdata_i (sp_wdata_i),
    .rdata_o (sp_rdata)
  );

  // external-data move routing
  wire [15:0] x_addr   = xmov_use_data_pointer16_i ? data_pointer16_i
                                         : {8'h00, index_reg_i};
  wire in_aux_range    = (x_addr <= AUX_TOP);
  wire to_aux          = aux_en && (!xmov_use_data_pointer16_i || in_aux_range);
  wire aux_hit         = xmov_req_i && to_aux;
  wire x_ext           = xmov_req_i && !to_aux;
  wire aux_write       = aux_hit && xmov_we_i;
  mab_ram u_aux (
    .clk_i   (clk_i),
    .we_i    (aux_write),
    .addr_i  (x_addr[7:0]),
    .wdata_i (xmov_wdata_i),
    .rdata_o (aux_rdata)
  );

  // external code fetch when the select input is low
  wire fetch_ext = fetch_req_i && !ea_s2;

  // bus sequencer, aligned to state times
  mab_cyc_e   cyc, next_cyc;
  logic [15:0] cyc_addr;
  logic [7:0]  cyc_wdata;
  logic        int_rd_pend, int_from_aux;
  // a taken request waits for the machine-cycle boundary, so both
  // latch pulses of the cycle carry its address
  logic        bus_run, ext_done;
  wire start_pt   = phase_en && (st == LAST_STATE);
  wire can_start  = (cyc == MAB_IDLE) && !busy_o;
  wire new_ext    = fetch_ext || x_ext;
  always_comb begin
    next_cyc = cyc;
    unique case (cyc)
      MAB_IDLE:  if (can_start && new_ext)
                   next_cyc = fetch_ext ? MAB_FETCH
                            : (xmov_we_i ? MAB_XWR : MAB_XRD);
      MAB_FETCH,
      MAB_XRD,
      MAB_XWR:   if (start_pt && bus_run)
                   next_cyc = MAB_IDLE;
    endcase
  end

  logic       ale_q, program_fetch_strobe_n_q, rd_n_q, wr_n_q, drive_q;
  logic [7:0] p0_q, p2_q;
  wire ext_cyc   = (cyc != MAB_IDLE) && bus_run;
  wire ale_slot  = (st == ALE_STATE_A) || (st == ALE_STATE_B);
  wire addr_slot = (st == ADDR_STATE_A) || (st == ADDR_STATE_B);
  wire data_slot = !ale_slot && !addr_slot;
  wire ale_now   = phase_en && ale_slot;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || dev_rst) begin
      cyc <= MAB_IDLE;
      cyc_addr <= 16'h0000;
      cyc_wdata <= 8'h00;
      ale_q <= 1'b0;
      program_fetch_strobe_n_q <= 1'b1;
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      drive_q <= 1'b0;
      p0_q <= PORT_RST;
      p2_q <= PORT_RST;
      busy_o <= 1'b0;
      rdata_o <= 8'h00;
      rvalid_o <= 1'b0;
      int_rd_pend <= 1'b0;
      int_from_aux <= 1'b0;
      bus_run <= 1'b0;
      ext_done <= 1'b0;
    end else begin
      cyc <= next_cyc;
      if (cyc == MAB_IDLE && next_cyc != MAB_IDLE) begin
        cyc_addr  <= fetch_ext ? pc_i : x_addr;
        cyc_wdata <= xmov_wdata_i;
        busy_o    <= 1'b1;
      end else if (ext_cyc && start_pt) begin
        busy_o <= 1'b0;
      end
      if (cyc != MAB_IDLE && start_pt)
        bus_run <= !bus_run;
      ale_q <= ale_now;
      // fetch strobe only in external fetch data window
      program_fetch_strobe_n_q <= !(ext_cyc && cyc == MAB_FETCH && data_slot);
      rd_n_q   <= !(ext_cyc && cyc == MAB_XRD && data_slot);
      wr_n_q   <= !(ext_cyc && cyc == MAB_XWR && data_slot);
      if (ext_cyc) begin
        p2_q    <= cyc_addr[15:8];
        drive_q <= (ale_slot || addr_slot) || (cyc == MAB_XWR);
        p0_q    <= (ale_slot || addr_slot) ? cyc_addr[7:0]
                                           : cyc_wdata;
      end else begin
        // internal and auxiliary accesses leave the pins at latch values
        p2_q    <= p2_latch;
        p0_q    <= p0_latch;
        drive_q <= 1'b0;
      end
      int_rd_pend  <= (sp_ok && !sp_we_i) || (aux_hit && !xmov_we_i);
      int_from_aux <= aux_hit;
      // one cycle after the end the synchroniser holds the last strobe window
      ext_done <= ext_cyc && start_pt && (cyc == MAB_XRD || cyc == MAB_FETCH);
      rvalid_o <= int_rd_pend || ext_done;
      if (int_rd_pend)
        rdata_o <= int_from_aux ? aux_rdata : sp_rdata;
      else if (ext_done)
        rdata_o <= p0_s2;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      chip_control_reg_o <= CHIP_CTRL_RST;
      reset_active_o <= 1'b1;
    end else begin
      chip_control_reg_o <= chip_ctrl;
      reset_active_o <= dev_rst;
    end
  end

  assign low_addr_data_port_o     = p0_q;
  assign low_addr_data_port_oe_o  = drive_q;
  assign high_addr_port_o         = p2_q;
  assign program_fetch_strobe_n_o = program_fetch_strobe_n_q;
  assign addr_latch_strobe_o      = ale_q;
  assign ext_rd_n_o               = rd_n_q;
  assign ext_wr_n_o               = wr_n_q;
endmodule

// file: src/mab_pkg.sv
// shared constants for the memory access bus block
package mab_pkg;
  // timing: one machine cycle is twelve oscillator periods
  localparam int unsigned OSC_PER_MC     = 12;
  localparam int unsigned OSC_DIV        = 2;
  localparam int unsigned STATE_PER_MC   = 6;
  localparam int unsigned ALE_PER_MC     = 2;
  localparam int unsigned RST_HOLD_MC    = 2;
  localparam logic [2:0]  SAMPLE_STATE   = 3'h4;
  localparam logic [2:0]  ALE_STATE_A    = 3'h0;
  localparam logic [2:0]  ALE_STATE_B    = 3'h3;
  localparam logic [2:0]  ADDR_STATE_A   = 3'h5;
  localparam logic [2:0]  ADDR_STATE_B   = 3'h2;
  localparam logic [2:0]  LAST_STATE     = 3'h5;
  // memory sizes
  localparam int unsigned RAM_DEPTH      = 256;
  localparam int unsigned DIRECT_LIMIT   = 128;
  // chip control register
  localparam int unsigned AUX_EN_BIT     = 4;
  localparam logic [7:0]  CHIP_CTRL_RST  = 8'h00;
  localparam logic [7:0]  PORT_RST       = 8'hff;
  localparam logic [15:0] AUX_TOP        = 16'h00ff;
  // bus cycle kinds
  typedef enum logic [3:0] {
    MAB_IDLE  = 4'h1,
    MAB_FETCH = 4'h2,
    MAB_XRD   = 4'h4,
    MAB_XWR   = 4'h8
  } mab_cyc_e;
endpackage

// file: src/mab_clkdiv.sv
// oscillator divider making the state-time enable
`timescale 1ns/1ps
module mab_clkdiv (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  output logic            phase_en_o,
  output logic [2:0]      state_o
);
  import mab_pkg::*;
  logic       half;
  wire        tick   = half;
  wire        last   = (state_o == LAST_STATE);
  // divide by two: one state time is two oscillator periods
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      half <= 1'b0;
      phase_en_o <= 1'b0;
      state_o <= 3'h0;
    end else begin
      half <= ~half;
      phase_en_o <= tick;
      if (tick)
        state_o <= last ? 3'h0 : state_o + 3'h1;
    end
  end
endmodule

// file: src/mab_ram.sv
// single-port 256 byte RAM bank
`timescale 1ns/1ps
module mab_ram (
  input  wire logic       clk_i,
  input  wire logic       we_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] rdata_o
);
  import mab_pkg::*;
  logic [7:0] mem [0:RAM_DEPTH-1];
  always_ff @(posedge clk_i) begin
    if (we_i)
      mem[addr_i] <= wdata_i;
    rdata_o <= mem[addr_i];
  end
endmodule

// file: tb/mab_checker.sv
// port assertions for the memory access bus block
`timescale 1ns/1ps
module mab_checker
  import mab_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic       reset_pin_i,
  input wire logic       ext_fetch_select_n_i,
  input wire logic       sp_req_i,
  input wire logic       sp_we_i,
  input wire logic       sp_indirect_i,
  input wire logic [7:0] sp_addr_i,
  input wire logic       xmov_req_i,
  input wire logic       xmov_use_data_pointer16_i,
  input wire logic       low_addr_data_port_oe_o,
  input wire logic [7:0] high_addr_port_o,
  input wire logic       program_fetch_strobe_n_o,
  input wire logic       addr_latch_strobe_o,
  input wire logic       ext_rd_n_o,
  input wire logic       ext_wr_n_o,
  input wire logic       rvalid_o,
  input wire logic       busy_o,
  input wire logic [7:0] chip_control_reg_o,
  input wire logic       reset_active_o
);
  logic [7:0] ea_cnt;
  logic [7:0] pin_cnt;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ea_cnt  <= 8'h00;
      pin_cnt <= 8'h00;
    end else begin
      ea_cnt  <= ext_fetch_select_n_i ? ea_cnt + {7'h00, ~&ea_cnt} : 8'h00;
      pin_cnt <= reset_pin_i ? pin_cnt + {7'h00, ~&pin_cnt} : 8'h00;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_rst_ports: assert property (disable iff (1'b0) !rst_n_i |=>
    high_addr_port_o == PORT_RST && !low_addr_data_port_oe_o &&
    program_fetch_strobe_n_o && chip_control_reg_o == CHIP_CTRL_RST)
    else $error("ports not at reset level");
  a_ale_single: assert property (addr_latch_strobe_o |=>
    !addr_latch_strobe_o [*5]) else $error("latch strobe too often");
  a_fetch_release: assert property (!program_fetch_strobe_n_o |->
    !low_addr_data_port_oe_o) else $error("low port driven in fetch");
  a_rd_release: assert property (!ext_rd_n_o |->
    !low_addr_data_port_oe_o && ext_wr_n_o) else $error("read clash");
  a_wr_drive: assert property (!ext_wr_n_o |->
    low_addr_data_port_oe_o) else $error("write data not driven");
  a_int_quiet: assert property (ea_cnt > 8'h3c |->
    program_fetch_strobe_n_o) else $error("strobe on internal fetch");
  a_aux_quiet: assert property (xmov_req_i && !xmov_use_data_pointer16_i &&
    chip_control_reg_o[AUX_EN_BIT] && !busy_o && ea_cnt > 8'h3c |=>
    (ext_rd_n_o && ext_wr_n_o && !busy_o) [*4])
    else $error("aux access reached bus");
  a_sp_answer: assert property (sp_req_i && !sp_we_i &&
    (sp_indirect_i || !sp_addr_i[7]) |-> ##2 rvalid_o)
    else $error("scratchpad read unanswered");
  a_sp_refuse: assert property (sp_req_i && !sp_indirect_i &&
    sp_addr_i[7] && !xmov_req_i && !busy_o |-> ##2 !rvalid_o)
    else $error("direct upper access answered");
  a_pin_reset: assert property (pin_cnt > 8'h6e |->
    reset_active_o) else $error("held pin did not reset");
endmodule

// file: tb/mab_ext_mem.sv
// external memory with address latch on the multiplexed bus
`timescale 1ns/1ps
module mab_ext_mem (
  input  wire logic       clk_i,
  input  wire logic       ale_i,
  input  wire logic [7:0] ad_i,
  input  wire logic [7:0] hi_i,
  input  wire logic       rd_n_i,
  output logic      [7:0] ad_o
);
  logic [7:0] lat = 8'h00;
  logic [7:0] last = 8'h00;
  // latch takes the low address byte while the strobe is high
  always @(posedge clk_i) if (ale_i) lat <= ad_i;
  always @(posedge clk_i) if (!rd_n_i) last <= lat ^ hi_i ^ 8'h5a;
  // released bus shows the inverse of the last byte
  assign ad_o = !rd_n_i ? (lat ^ hi_i ^ 8'h5a) : ~last;
endmodule

// file: tb/tb_mcu_memory_access_bus.sv
// self-checking bench for the memory access bus block
`timescale 1ns/1ps
module tb_mcu_memory_access_bus;
  import mab_pkg::*;
  logic clk_i = 0, rst_n_i = 0, pin = 0, ea = 1, fr = 0, sr = 0, swe = 0;
  logic sind = 0, xr = 0, xwe = 0, xdp = 0, cwe = 0, pwe = 0;
  logic [15:0] pc = 0, dp = 0;
  logic [7:0]  sa = 0, sw = 0, ix = 0, xw = 0, cw = 0, md, ad, hi, rd, cr;
  logic        oe, psn, ale, rdn, wrn, rv, bsy, ra, ps_seen, rd_seen;
  logic [7:0]  hi_at, wr_at;
  int          n_errors = 0, tests_run = 0;
  always #12.5 clk_i = ~clk_i;
  mab_top u_dut (.clk_i, .rst_n_i, .reset_pin_i(pin),
    .ext_fetch_select_n_i(ea), .fetch_req_i(fr), .pc_i(pc), .sp_req_i(sr),
    .sp_we_i(swe), .sp_indirect_i(sind), .sp_addr_i(sa), .sp_wdata_i(sw),
    .xmov_req_i(xr), .xmov_we_i(xwe), .xmov_use_data_pointer16_i(xdp),
    .index_reg_i(ix), .data_pointer16_i(dp), .xmov_wdata_i(xw),
    .chip_ctrl_we_i(cwe), .chip_ctrl_wdata_i(cw), .port0_latch_i(8'h00),
    .port2_latch_i(8'h00), .port_latch_we_i(pwe),
    .low_addr_data_port_i(md), .low_addr_data_port_o(ad),
    .low_addr_data_port_oe_o(oe), .high_addr_port_o(hi),
    .program_fetch_strobe_n_o(psn), .addr_latch_strobe_o(ale),
    .ext_rd_n_o(rdn), .ext_wr_n_o(wrn), .rdata_o(rd), .rvalid_o(rv),
    .busy_o(bsy), .chip_control_reg_o(cr), .reset_active_o(ra));
  mab_ext_mem u_mem (.clk_i, .ale_i(ale), .ad_i(ad), .hi_i(hi),
    .rd_n_i(psn & rdn), .ad_o(md));
  always @(posedge clk_i) begin
    if (psn === 1'b0) begin ps_seen <= 1; hi_at <= hi; end
    if (rdn === 1'b0) rd_seen <= 1;
    if (wrn === 1'b0) wr_at <= ad;
  end
  task chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task final_report;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task cyc(input int n); repeat (n) @(posedge clk_i); #2; endtask
  task wait_rv(input int n, output logic [7:0] d, output logic g);
    g = 0;
    repeat (n) if (!g) begin cyc(1); if (rv === 1'b1) begin g = 1; d = rd; end end
  endtask
  task wait_idle; repeat (100) if (bsy !== 1'b0) cyc(1); endtask
  task sp(input logic we, i, input logic [7:0] a, w);
    sr = 1; swe = we; sind = i; sa = a; sw = w; cyc(1); sr = 0;
  endtask
  task xm(input logic we, p, input logic [15:0] a, input logic [7:0] w);
    xr = 1; xwe = we; xdp = p; ix = a[7:0]; dp = a; xw = w; cyc(1); xr = 0;
  endtask
  task wait_ra; repeat (120) if (ra !== 1'b0) cyc(1); endtask
  task t_ale; int n;
    n = 0; repeat (60) if (ale !== 1'b1) cyc(1); cyc(1);
    while (ale !== 1'b1 && n < 60) begin n++; cyc(1); end
    chk(n == OSC_PER_MC / ALE_PER_MC - 1, "latch strobe period");
  endtask
  task t_sp; logic [7:0] d; logic g;
    sp(1, 0, 8'h10, 8'ha5); cyc(1); sp(1, 1, 8'h90, 8'h3c); cyc(1);
    sp(1, 0, 8'h90, 8'h00); cyc(1);
    sp(0, 0, 8'h10, 0); wait_rv(4, d, g); chk(g && d === 8'ha5, "direct");
    sp(0, 1, 8'h10, 0); wait_rv(4, d, g); chk(g && d === 8'ha5, "indirect");
    sp(0, 1, 8'h90, 0); wait_rv(4, d, g); chk(g && d === 8'h3c, "upper");
    sp(0, 0, 8'h90, 0); wait_rv(4, d, g); chk(!g, "direct upper");
  endtask
  task t_aux; logic [7:0] d; logic g;
    chk(cr[AUX_EN_BIT] === 1'b0, "aux on after reset");
    rd_seen = 0; xm(0, 0, 16'h0020, 0); wait_rv(100, d, g);
    chk(g && rd_seen, "disabled move off bus");
    wait_idle; cw = 8'h10; cwe = 1; cyc(1); cwe = 0; cyc(1);
    chk(cr[AUX_EN_BIT] === 1'b1, "enable bit");
    rd_seen = 0; xm(1, 0, 16'h0020, 8'h77); cyc(1); xm(0, 1, 16'h0020, 0);
    wait_rv(4, d, g); chk(g && d === 8'h77, "pointer to aux");
    xm(0, 0, 16'h0120, 0); wait_rv(4, d, g);
    chk(g && d === 8'h77 && !rd_seen, "index to aux");
    xm(0, 1, 16'h0120, 0); wait_rv(100, d, g);
    chk(g && rd_seen && d === (8'h20 ^ 8'h01 ^ 8'h5a), "above aux");
    wait_idle; xm(1, 1, 16'h0300, 8'h99); wait_idle;
    chk(wr_at === 8'h99, "external write");
  endtask
  task t_fetch; logic [7:0] d; logic g;
    ea = 0; cyc(4); ps_seen = 0; pc = 16'h1234; fr = 1;
    wait_rv(100, d, g); fr = 0;
    chk(g && ps_seen && d === (8'h34 ^ 8'h12 ^ 8'h5a), "ext fetch");
    chk(hi_at === 8'h12, "upper address");
    wait_idle; ea = 1; cyc(100); ps_seen = 0; fr = 1; cyc(100); fr = 0;
    chk(!ps_seen, "strobe on internal fetch");
  endtask
  task t_rst;
    pwe = 1; cyc(1); pwe = 0; cyc(1);
    chk(hi === 8'h00 && ad === 8'h00, "port load");
    pin = 1; cyc(10); pin = 0; cyc(4); chk(ra === 1'b0, "short pulse");
    cyc(20); pin = 1; cyc(120); chk(ra === 1'b1, "pin reset");
    chk(hi === PORT_RST && ad === PORT_RST, "port reset values");
    chk(cr === CHIP_CTRL_RST, "control reset value");
    pin = 0; wait_ra; chk(ra === 1'b0, "reset release");
  endtask
  initial begin
    cyc(3); rst_n_i = 1; wait_ra;
    chk(ra === 1'b0, "reset stuck");
    t_ale; t_sp; t_aux; t_fetch; t_rst;
    final_report;
  end
  initial begin #200000; n_errors++; final_report; end
endmodule
bind mab_top mab_checker u_chk (.clk_i, .rst_n_i, .reset_pin_i,
  .ext_fetch_select_n_i, .sp_req_i, .sp_we_i, .sp_indirect_i, .sp_addr_i,
  .xmov_req_i, .xmov_use_data_pointer16_i, .low_addr_data_port_oe_o,
  .high_addr_port_o, .program_fetch_strobe_n_o, .addr_latch_strobe_o,
  .ext_rd_n_o, .ext_wr_n_o, .rvalid_o, .busy_o, .chip_control_reg_o,
  .reset_active_o);
